// ==== logic/port_cap_pkg.sv ====
// constants for the switch port capability register bank
package port_cap_pkg;
  localparam logic [7:0]  OFF_MSI_UPPER     = 8'h54;
  localparam logic [7:0]  OFF_MSI_PAYLOAD   = 8'h58;
  localparam logic [7:0]  OFF_PD_CAP_CTRL   = 8'h5c;
  localparam logic [7:0]  OFF_PD_WORD       = 8'h60;
  localparam logic [7:0]  OFF_VENDOR_HDR    = 8'h64;
  localparam logic [7:0]  OFF_TEST_CTRL0    = 8'h68;
  localparam logic [7:0]  OFF_TEST_CTRL1    = 8'h6c;
  localparam logic [7:0]  OFF_REPLAY        = 8'h70;
  localparam logic [7:0]  OFF_MSI_CTRL_CAP  = 8'h4c;
  localparam logic [7:0]  OFF_IRQ_STATUS    = 8'h80;
  localparam logic [7:0]  OFF_IRQ_ENABLE    = 8'h84;
  localparam logic [7:0]  OFF_IRQ_CLEAR     = 8'h88;
  localparam logic [7:0]  PD_CAP_ID         = 8'h03;
  localparam logic [7:0]  PD_NEXT_PTR       = 8'h64;
  localparam logic [7:0]  VENDOR_CAP_ID     = 8'h09;
  localparam logic [7:0]  VENDOR_NEXT_PTR   = 8'hb0;
  localparam logic [15:0] VENDOR_LENGTH     = 16'h0034;
  localparam int          PD_LOC_LSB        = 18;
  localparam int          PD_WEN_BIT        = 30;
  localparam int          PD_OP_BIT         = 31;
  localparam int          MSI_64BIT_BIT     = 23;
  localparam int          TC_ROLE_CHG_BIT   = 1;
  localparam int          TC_NO_HOTRST_BIT  = 2;
  localparam int          TC_ROLE_SEL_BIT   = 3;
  localparam int          TC_STRAP_LSB      = 13;
  localparam int          RP_ENABLE_BIT     = 12;
  localparam int          RP_PM_DIS_BIT     = 13;
  localparam int          RP_MSI_DIS_BIT    = 14;
  localparam logic [31:0] TEST_CTRL0_RESET  = 32'h04001060;
  localparam logic [31:0] TEST_CTRL1_RESET  = 32'h04000800;
  localparam logic [1:0]  AXI_OKAY          = 2'h0;
  localparam logic [1:0]  AXI_SLVERR        = 2'h2;
  localparam int          EE_CYCLE_NS       = 1000;
  localparam int          CLK_PERIOD_NS     = 25;
  localparam int          EE_CYCLES         = EE_CYCLE_NS / CLK_PERIOD_NS;
endpackage

// ==== logic/product_data_engine.sv ====
// serial eeprom access sequencer for product data reads and writes
`timescale 1ns/1ps
module product_data_engine
  import port_cap_pkg::*;
(
  input  wire logic        clk_sys,      // core clock
  input  wire logic        rst_n,        // async reset, active low
  input  wire logic        start,        // one-cycle start pulse
  input  wire logic        is_write,     // 1 write, 0 read
  input  wire logic [5:0]  location,     // dword location
  input  wire logic [31:0] wr_data,      // data to store
  output logic             ee_req,       // eeprom request level
  output logic             ee_we,        // eeprom write select
  output logic [5:0]       ee_addr,      // eeprom dword address
  output logic [31:0]      ee_wdata,     // eeprom write data
  input  wire logic        ee_ack,       // eeprom cycle done pulse
  input  wire logic [31:0] ee_rdata,     // eeprom read data
  output logic             busy,         // cycle under way
  output logic             done,         // one-cycle completion pulse
  output logic [31:0]      rd_data       // fetched word
);
  typedef enum logic [0:0] {IDLE, WAIT_ACK} eng_state_type;
  eng_state_type state_reg;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= IDLE;
      ee_we     <= 1'b0;
      ee_addr   <= 6'h00;
      ee_wdata  <= 32'h00000000;
      rd_data   <= 32'h00000000;
      done      <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      unique case (state_reg)
        IDLE:
        begin
          if (start)
          begin
            state_reg <= WAIT_ACK;
            ee_we     <= is_write;
            ee_addr   <= location;
            ee_wdata  <= wr_data;
          end
        end
        WAIT_ACK:
        begin
          if (ee_ack)
          begin
            state_reg <= IDLE;
            done      <= 1'b1;
            if (!ee_we)
              rd_data <= ee_rdata;
          end
        end
      endcase
    end
  end
  assign ee_req = (state_reg == WAIT_ACK);
  assign busy   = (state_reg == WAIT_ACK);
endmodule // product_data_engine

// ==== logic/switch_port_cap_config_regs.sv ====
// capability and test configuration registers of one switch port
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module switch_port_cap_config_regs
  import port_cap_pkg::*;
(
  input  wire logic        clk_sys,          // core clock, 40 MHz
  input  wire logic        rst_n,            // async reset, active low
  input  wire logic [7:0]  s_axi_awaddr,     // write address
  input  wire logic        s_axi_awvalid,    // write address valid
  output logic             s_axi_awready,    // write address ready
  input  wire logic [31:0] s_axi_wdata,      // write data
  input  wire logic [3:0]  s_axi_wstrb,      // write byte strobes
  input  wire logic        s_axi_wvalid,     // write data valid
  output logic             s_axi_wready,     // write data ready
  output logic [1:0]       s_axi_bresp,      // write response
  output logic             s_axi_bvalid,     // write response valid
  input  wire logic        s_axi_bready,     // write response ready
  input  wire logic [7:0]  s_axi_araddr,     // read address
  input  wire logic        s_axi_arvalid,    // read address valid
  output logic             s_axi_arready,    // read address ready
  output logic [31:0]      s_axi_rdata,      // read data
  output logic [1:0]       s_axi_rresp,      // read response
  output logic             s_axi_rvalid,     // read data valid
  input  wire logic        s_axi_rready,     // read data ready
  output logic             ee_req,           // eeprom cycle request level
  output logic             ee_we,            // eeprom write select
  output logic [5:0]       ee_addr,          // eeprom dword address
  output logic [31:0]      ee_wdata,         // eeprom write data
  input  wire logic        ee_ack,           // eeprom cycle done pulse
  input  wire logic [31:0] ee_rdata,         // eeprom read data
  input  wire logic        load_valid,       // autoload of defaults pulse
  input  wire logic [1:0]  load_strap,       // autoload test control bits 14:13
  input  wire logic [14:0] load_replay,      // autoload replay word bits 14:0
  input  wire logic        upstream_link_up, // upstream link state
  input  wire logic        hot_reset_in,     // hot reset seen upstream
  output logic             hot_reset_down,   // hot reset to downstream ports
  output logic             role_downstream,  // link training role select
  output logic             replay_use_user,  // replay timer uses user value
  output logic [11:0]      replay_user_val,  // user replay time-out
  output logic             msi_addr_64,      // upper address word in effect
  output logic [31:0]      msi_upper_eff,    // effective upper address
  output logic             pm_cap_disable,   // power management cap off
  output logic             msi_cap_disable,  // interrupt cap off
  output logic             irq               // interrupt level
);
  logic [31:0] msi_upper_reg;
  logic [15:0] msi_payload_reg;
  logic [5:0]  pd_loc_reg;
  logic        pd_wen_reg;
  logic        pd_op_reg;
  logic [31:0] pd_word_reg;
  logic [31:0] test_ctrl0_reg;
  logic [31:0] test_ctrl1_reg;
  logic [14:0] replay_reg;
  logic [1:0]  irq_status_reg;
  logic [1:0]  irq_enable_reg;
  logic        role_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [31:0] rdata_next;
  logic        pd_start;
  logic        pd_busy;
  logic        pd_done;
  logic [31:0] pd_rd_data;
  logic        pd_done_write;

  function automatic logic [31:0] merge
  (
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    return res;
  endfunction

  // write channel: address and data may arrive in either order
  wire         aw_take   = s_axi_awvalid && !aw_held_reg && !s_axi_bvalid;
  wire         w_take    = s_axi_wvalid && !w_held_reg && !s_axi_bvalid;
  wire         aw_have   = aw_held_reg || aw_take;
  wire         w_have    = w_held_reg || w_take;
  wire         wr_fire   = aw_have && w_have;
  wire  [7:0]  wr_addr   = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire  [31:0] wr_data   = w_held_reg ? wdata_reg : s_axi_wdata;
  wire  [3:0]  wr_strb   = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire  [31:0] wr_merged_pd   = merge({pd_op_reg, pd_wen_reg, 6'h00, pd_loc_reg,
                                       18'h00000}, wr_data, wr_strb);
  wire         wr_upper  = wr_fire && wr_addr == OFF_MSI_UPPER;
  wire         wr_pay    = wr_fire && wr_addr == OFF_MSI_PAYLOAD;
  wire         wr_pdctl  = wr_fire && wr_addr == OFF_PD_CAP_CTRL;
  wire         wr_pdword = wr_fire && wr_addr == OFF_PD_WORD;
  wire         wr_tc0    = wr_fire && wr_addr == OFF_TEST_CTRL0;
  wire         wr_tc1    = wr_fire && wr_addr == OFF_TEST_CTRL1;
  wire         wr_replay = wr_fire && wr_addr == OFF_REPLAY;
  wire         wr_irqen  = wr_fire && wr_addr == OFF_IRQ_ENABLE;
  wire         wr_irqclr = wr_fire && wr_addr == OFF_IRQ_CLEAR;
  wire         wr_mapped = wr_upper || wr_pay || wr_pdctl || wr_pdword || wr_tc0
                           || wr_tc1 || wr_replay || wr_irqen || wr_irqclr
                           || (wr_addr == OFF_MSI_CTRL_CAP) || (wr_addr == OFF_VENDOR_HDR)
                           || (wr_addr == OFF_IRQ_STATUS);
  // op byte carries the start; ignored while a cycle runs
  wire         pd_op_new = wr_merged_pd[PD_OP_BIT];
  wire         pd_wen_new = wr_merged_pd[PD_WEN_BIT];
  assign pd_start = wr_pdctl && wr_strb[3] && !pd_busy
                    && (!pd_op_new || pd_wen_new);

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? AXI_OKAY : AXI_SLVERR;
      end
      else
      begin
        if (aw_take)
        begin
          aw_held_reg <= 1'b1;
          awaddr_reg  <= s_axi_awaddr;
        end
        if (w_take)
        begin
          w_held_reg <= 1'b1;
          wdata_reg  <= s_axi_wdata;
          wstrb_reg  <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register storage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      msi_upper_reg   <= 32'h00000000;
      msi_payload_reg <= 16'h0000;
      test_ctrl1_reg  <= TEST_CTRL1_RESET;
      irq_enable_reg  <= 2'h0;
    end
    else
    begin
      if (wr_upper)
        msi_upper_reg <= merge(msi_upper_reg, wr_data, wr_strb);
      if (wr_pay)
        msi_payload_reg <= 16'(merge({16'h0000, msi_payload_reg}, wr_data,
                                 wr_strb));
      if (wr_tc1)
        test_ctrl1_reg <= merge(test_ctrl1_reg, wr_data, wr_strb);
      if (wr_irqen)
        irq_enable_reg <= wr_data[1:0];
    end
  end

  // test control 0 and replay word, with autoload of defaults
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      test_ctrl0_reg <= TEST_CTRL0_RESET;
      replay_reg     <= 15'h0000;
      role_reg       <= TEST_CTRL0_RESET[TC_ROLE_SEL_BIT];
    end
    else
    begin
      if (wr_tc0)
        test_ctrl0_reg <= merge(test_ctrl0_reg, wr_data, wr_strb);
      else if (load_valid)
        test_ctrl0_reg[TC_STRAP_LSB +: 2] <= load_strap;
      if (wr_replay)
        replay_reg[12:0] <= 13'(merge({17'h00000, replay_reg}, wr_data,
                                  wr_strb));
      else if (load_valid)
        replay_reg <= load_replay;
      if (test_ctrl0_reg[TC_ROLE_CHG_BIT])
        role_reg <= test_ctrl0_reg[TC_ROLE_SEL_BIT];
    end
  end

  // product data control: flag held during the eeprom cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pd_loc_reg  <= 6'h00;
      pd_wen_reg  <= 1'b0;
      pd_op_reg   <= 1'b0;
      pd_word_reg <= 32'h00000000;
    end
    else
    begin
      if (wr_pdctl && !pd_busy)
      begin
        pd_loc_reg <= wr_merged_pd[PD_LOC_LSB +: 6];
        pd_wen_reg <= pd_wen_new;
      end
      if (pd_start)
        pd_op_reg <= pd_op_new;
      else if (pd_done)
        pd_op_reg <= !pd_done_write;
      if (pd_done && !pd_done_write)
        pd_word_reg <= pd_rd_data;
      else if (wr_pdword && !pd_busy)
        pd_word_reg <= merge(pd_word_reg, wr_data, wr_strb);
    end
  end

  logic pd_kind_reg;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pd_kind_reg <= 1'b0;
    else if (pd_start)
      pd_kind_reg <= pd_op_new;
  end
  assign pd_done_write = pd_kind_reg;

  product_data_engine u_engine
  (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .start    (pd_start),
    .is_write (pd_op_new),
    .location (wr_merged_pd[PD_LOC_LSB +: 6]),
    .wr_data  (pd_word_reg),
    .ee_req   (ee_req),
    .ee_we    (ee_we),
    .ee_addr  (ee_addr),
    .ee_wdata (ee_wdata),
    .ee_ack   (ee_ack),
    .ee_rdata (ee_rdata),
    .busy     (pd_busy),
    .done     (pd_done),
    .rd_data  (pd_rd_data)
  );

  // interrupt: bit 0 read done, bit 1 write done; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq_status_reg <= 2'h0;
    else
      irq_status_reg <= (irq_status_reg & ~(wr_irqclr ? wr_data[1:0] : 2'h0))
                        | {pd_done && pd_done_write, pd_done && !pd_done_write};
  end
  assign irq = |(irq_status_reg & irq_enable_reg);

  // read channel
  always_comb
  begin
    unique case (s_axi_araddr)
      OFF_MSI_CTRL_CAP: rdata_next = 32'h00000000 | (32'h1 << MSI_64BIT_BIT);
      OFF_MSI_UPPER:    rdata_next = msi_upper_reg;
      OFF_MSI_PAYLOAD:  rdata_next = {16'h0000, msi_payload_reg};
      OFF_PD_CAP_CTRL:  rdata_next = {pd_op_reg, pd_wen_reg, 6'h00, pd_loc_reg, 2'h0,
                                      PD_NEXT_PTR, PD_CAP_ID};
      OFF_PD_WORD:      rdata_next = pd_word_reg;
      OFF_VENDOR_HDR:   rdata_next = {VENDOR_LENGTH, VENDOR_NEXT_PTR,
                                      VENDOR_CAP_ID};
      OFF_TEST_CTRL0:   rdata_next = test_ctrl0_reg;
      OFF_TEST_CTRL1:   rdata_next = test_ctrl1_reg;
      OFF_REPLAY:       rdata_next = {17'h00000, replay_reg};
      OFF_IRQ_STATUS:   rdata_next = {30'h00000000, irq_status_reg};
      OFF_IRQ_ENABLE:   rdata_next = {30'h00000000, irq_enable_reg};
      default:          rdata_next = 32'h00000000;
    endcase
  end
  wire rd_mapped = s_axi_araddr inside {OFF_MSI_CTRL_CAP, OFF_MSI_UPPER, OFF_MSI_PAYLOAD,
                   OFF_PD_CAP_CTRL, OFF_PD_WORD, OFF_VENDOR_HDR, OFF_TEST_CTRL0,
                   OFF_TEST_CTRL1, OFF_REPLAY, OFF_IRQ_STATUS, OFF_IRQ_ENABLE,
                   OFF_IRQ_CLEAR};
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_next;
      s_axi_rresp  <= rd_mapped ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // outputs to the port logic
  assign msi_addr_64     = 1'b1;
  assign msi_upper_eff   = msi_addr_64 ? msi_upper_reg : 32'h00000000;
  assign role_downstream = role_reg;
  assign hot_reset_down  = hot_reset_in && !(test_ctrl0_reg[TC_NO_HOTRST_BIT]
                           && !upstream_link_up);
  assign replay_use_user = replay_reg[RP_ENABLE_BIT];
  assign replay_user_val = replay_reg[11:0];
  assign pm_cap_disable  = replay_reg[RP_PM_DIS_BIT];
  assign msi_cap_disable = replay_reg[RP_MSI_DIS_BIT];

  AST_READ_FLAG_ONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pd_done && !pd_done_write |=> pd_op_reg) else $error("read end not flagged");
  AST_WRITE_FLAG_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pd_done && pd_done_write |=> !pd_op_reg) else $error("write end not cleared");
  AST_FLAG_HELD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pd_busy && !pd_done |-> pd_op_reg == pd_kind_reg) else $error("flag moved");
  AST_READ_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pd_done && !pd_done_write |=> pd_word_reg == $past(pd_rd_data))
    else $error("fetched word lost");
  AST_WRITE_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ee_req && ee_we |-> ee_wdata == pd_word_reg) else $error("write data mismatch");
  AST_HOTRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    test_ctrl0_reg[TC_NO_HOTRST_BIT] && !upstream_link_up |-> !hot_reset_down)
    else $error("hot reset passed");
  AST_ROLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(test_ctrl0_reg[TC_ROLE_CHG_BIT]) |-> $stable(role_reg))
    else $error("role changed while locked");
  AST_LOC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pd_start |=> ee_addr == $past(wr_merged_pd[PD_LOC_LSB +: 6]))
    else $error("wrong location");
  AST_REPLAY_OUT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_replay |=> replay_use_user == $past(wr_strb[1] ? wr_data[12] : replay_reg[12]))
    else $error("replay enable lost");
endmodule // switch_port_cap_config_regs

// ==== testbench/eeprom_model.sv ====
// serial eeprom model holding the product data table
`timescale 1ns/1ps
module eeprom_model (
  input  wire logic        clk_sys,  // core clock
  input  wire logic        ee_req,   // cycle request level
  input  wire logic        ee_we,    // write select
  input  wire logic [5:0]  ee_addr,  // dword address
  input  wire logic [31:0] ee_wdata, // data to store
  input  wire logic [3:0]  dly,      // answer delay in cycles
  output logic             ee_ack,   // cycle done pulse
  output logic [31:0]      ee_rdata  // read data
);
  logic [31:0] mem [64];
  logic [3:0]  cnt;
  logic        served;
  initial
  begin
    ee_ack = 1'b0;
    ee_rdata = 32'h0;
    cnt = 4'h0;
    served = 1'b0;
    foreach (mem[i]) mem[i] = 32'h5a000000 + i;
  end
  always @(posedge clk_sys)
  begin
    ee_ack <= 1'b0;
    ee_rdata <= ~ee_rdata;
    cnt <= cnt + 4'h1;
    if (!ee_req)
    begin
      cnt <= 4'h0;
      served <= 1'b0;
    end
    else if (!served && cnt == dly)
    begin
      ee_ack <= 1'b1;
      served <= 1'b1;
      if (ee_we) mem[ee_addr] <= ee_wdata;
      else ee_rdata <= mem[ee_addr];
    end
  end
endmodule // eeprom_model

// ==== testbench/tb.sv ====
// self-checking bench for the port capability register bank
`timescale 1ns/1ps
module tb;
  import port_cap_pkg::*;
  logic        clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, ee_req, ee_we, ee_ack, load_valid, link_up, hr_in;
  logic        hr_dn, role, use_u, m64, pmd, msd, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdat, lfsr, ee_wdata, ee_rdata, upper;
  logic [3:0]  wstrb, dly;
  logic [1:0]  bresp, rresp, strap;
  logic [5:0]  ee_addr, loc;
  logic [11:0] uval;
  logic [14:0] lrep;
  logic [65:0] exp_q[$];
  logic [65:0] nt;
  int          num_errors, samples_checked;
  switch_port_cap_config_regs dut (.clk_sys, .rst_n, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ee_req, .ee_we, .ee_addr, .ee_wdata, .ee_ack, .ee_rdata, .load_valid,
    .load_strap(strap), .load_replay(lrep), .upstream_link_up(link_up), .hot_reset_in(hr_in),
    .hot_reset_down(hr_dn), .role_downstream(role), .replay_use_user(use_u),
    .replay_user_val(uval), .msi_addr_64(m64), .msi_upper_eff(upper), .pm_cap_disable(pmd),
    .msi_cap_disable(msd), .irq);
  eeprom_model ee (.clk_sys, .ee_req, .ee_we, .ee_addr, .ee_wdata, .dly, .ee_ack, .ee_rdata);
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(logic ok, string m);
    samples_checked++;
    if (!ok)
    begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'hf, logic [1:0] r = 2'h0);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk_sys); while (!bvalid);
    bready <= 1'b0;
    chk(bresp === r, "write response");
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m = '1, logic [1:0] r = 2'h0);
    exp_q.push_back({m, e, r});
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    rdat = rdata;
    rready <= 1'b0;
  endtask
  task automatic poll(logic want);
    do rd(OFF_PD_CAP_CTRL, 32'h0, 32'h0); while (rdat[31] !== want);
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys)
    if (rvalid && rready)
    begin
      nt = exp_q.pop_front();
      if (nt[65:34] != 32'h0) chk(((rdata ^ nt[33:2]) & nt[65:34]) === 32'h0
                                  && rresp === nt[1:0], "read data");
    end
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #1ms;
    num_errors++;
    print_verdict();
  end
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, load_valid, hr_in, rst_n} = '0;
    {awaddr, araddr, wdata, wstrb, strap, lrep} = '0;
    link_up = 1'b1;
    dly = 4'h8;
    lfsr = 32'h7ff98bf5;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFF_MSI_UPPER, 32'h0);
    rd(OFF_MSI_PAYLOAD, 32'h0);
    rd(OFF_PD_CAP_CTRL, 32'h00006403);
    rd(OFF_PD_WORD, 32'h0);
    rd(OFF_VENDOR_HDR, 32'h0034b009);
    rd(OFF_TEST_CTRL0, 32'h04001060);
    rd(OFF_TEST_CTRL1, 32'h04000800);
    rd(OFF_REPLAY, 32'h0, 32'hffff);
    rd(OFF_MSI_CTRL_CAP, 32'h00800000, 32'h00800000);
    rd(8'h90, 32'h0, '1, AXI_SLVERR);
    chk(m64 === 1'b1 && role === 1'b0 && use_u === 1'b0, "reset outputs");
    $display("test reset values done");
    lfsr = nxt(lfsr);
    wr(OFF_MSI_UPPER, lfsr);
    wr(OFF_MSI_UPPER, 32'h0, 4'h2);
    rd(OFF_MSI_UPPER, lfsr & 32'hffff00ff);
    chk(upper === (lfsr & 32'hffff00ff), "upper address");
    wr(OFF_TEST_CTRL1, lfsr);
    rd(OFF_TEST_CTRL1, lfsr);
    wr(OFF_MSI_PAYLOAD, '1);
    rd(OFF_MSI_PAYLOAD, 32'h0000ffff);
    wr(OFF_REPLAY, '1);
    rd(OFF_REPLAY, 32'h00001fff, 32'hffff);
    chk(use_u === 1'b1 && uval === 12'hfff && pmd === 1'b0, "replay outputs");
    wr(8'h90, 32'h0, 4'hf, AXI_SLVERR);
    $display("test read write done");
    repeat (2)
    begin
      lfsr = nxt(lfsr);
      dly <= lfsr[3:0] | 4'h8;
      loc = lfsr[9:4];
      wr(OFF_PD_WORD, lfsr);
      wr(OFF_PD_CAP_CTRL, {8'hc0, loc, 18'h0});
      rd(OFF_PD_CAP_CTRL, {8'h80, loc, 18'h0}, 32'h80fc0000);
      poll(1'b0);
      chk(ee.mem[loc] === lfsr, "stored word");
      wr(OFF_PD_WORD, ~lfsr);
      wr(OFF_PD_CAP_CTRL, {8'h00, loc, 18'h0});
      rd(OFF_PD_CAP_CTRL, 32'h0, 32'h80000000);
      poll(1'b1);
      rd(OFF_PD_WORD, lfsr);
    end
    rd(OFF_IRQ_STATUS, 32'h3);
    chk(irq === 1'b0, "masked interrupt");
    wr(OFF_IRQ_ENABLE, 32'h1);
    chk(irq === 1'b1, "raised interrupt");
    wr(OFF_IRQ_CLEAR, 32'h1);
    rd(OFF_IRQ_STATUS, 32'h2);
    chk(irq === 1'b0, "cleared interrupt");
    wr(OFF_PD_CAP_CTRL, 32'h80000000);
    rd(OFF_PD_CAP_CTRL, 32'h80006403);
    chk(ee_req === 1'b0, "write without enable started");
    $display("test product data done");
    wr(OFF_TEST_CTRL0, 32'h0000000a);
    repeat (2) @(posedge clk_sys);
    chk(role === 1'b1, "role change");
    wr(OFF_TEST_CTRL0, 32'h00000000);
    repeat (2) @(posedge clk_sys);
    chk(role === 1'b1, "role locked");
    wr(OFF_TEST_CTRL0, 32'h00000006);
    link_up <= 1'b0;
    hr_in <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(role === 1'b0 && hr_dn === 1'b0, "hot reset blocked");
    wr(OFF_TEST_CTRL0, 32'h00000002);
    chk(hr_dn === 1'b1, "hot reset passed");
    $display("test control done");
    load_valid <= 1'b1;
    strap <= 2'b11;
    lrep <= 15'h7abc;
    @(posedge clk_sys);
    load_valid <= 1'b0;
    rd(OFF_TEST_CTRL0, 32'h00006002);
    rd(OFF_REPLAY, 32'h00007abc, 32'hffff);
    chk(pmd === 1'b1 && msd === 1'b1 && uval === 12'habc && use_u === 1'b1, "autoload");
    $display("test autoload done");
    @(posedge clk_sys);
    print_verdict();
  end
endmodule // tb
